// ---- design/pwm_phase_frequency_config.sv ----
// Phase, output range, shared-clock and switching-rate configuration registers.
// Assumes a serial-bus front end that delivers decoded command writes as one-cycle strobes.
//
// Behaviour
// - Phase offsets are timed from the sync reference falling edge.
// - Configuration writes take effect only while the converter is off.
// - Writes while running are dropped, value kept, busy fault raised.
// - Bit 6 picks channel 0 range: one caps 2.75V, zero 4.096V.
// - Bit 5 picks channel 1 range: one caps 2.75V, zero 5.5V.
// - Bit 4 set: shared clock held low below on, pulled below off.
// - Bit 4 clear: shared clock only pulled low during first power-up.
// - Bits 2..0 choose the channel 0 / channel 1 phase pair.
// - Phase command carries one byte; bit 7 zero, bit 3 unused.
// - Rate command codes map to external or eight fixed frequencies.
// - Accepted rate change while off may flag loop unlock during relock.
// - Rate command carries two bytes in exponent/mantissa linear form.
`timescale 1ns/1ps
`include "pwm_cfg.svh"
module pwm_phase_frequency_config #(
	parameter int CNT_W = 16
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire pwm_cfg_pkg::cmd_write_type cmd_wr,
	input wire logic run_pins,
	input wire logic cmd_on,
	input wire logic sync_ref,
	input wire logic vin_above_on,
	input wire logic vin_below_off,
	input wire logic share_clk_in,
	output logic share_clk_out,
	output logic share_clk_oe,
	output logic [7:0] phase_cfg_rd,
	output logic [15:0] rate_sel_rd,
	output logic out0_range_select,
	output logic out1_range_select,
	output pwm_cfg_pkg::phase_pair_type phase_pair,
	output logic [3:0] rate_index,
	output logic ch0_phase_start,
	output logic ch1_phase_start,
	output pwm_cfg_pkg::fault_pulse_type faults
);
	import pwm_cfg_pkg::*;

	function automatic phase_pair_type phase_lookup(input logic [2:0] code);
		case (code)
			3'h0: phase_lookup = '{9'd0, 9'd180};
			3'h1: phase_lookup = '{9'd90, 9'd270};
			3'h2: phase_lookup = '{9'd0, 9'd240};
			3'h3: phase_lookup = '{9'd0, 9'd120};
			3'h4: phase_lookup = '{9'd120, 9'd240};
			3'h5: phase_lookup = '{9'd60, 9'd240};
			3'h6: phase_lookup = '{9'd120, 9'd300};
			default: phase_lookup = '{9'd0, 9'd180};
		endcase
	endfunction

	// Returns 0 for external, 1..8 for fixed rates, all ones when unsupported
	function automatic logic [3:0] rate_decode(input logic [15:0] code);
		case (code)
			`RATE_EXT: rate_decode = `RATE_IDX_EXT;
			`RATE_250: rate_decode = 4'h1;
			`RATE_350: rate_decode = 4'h2;
			`RATE_425: rate_decode = 4'h3;
			`RATE_500: rate_decode = 4'h4;
			`RATE_575: rate_decode = 4'h5;
			`RATE_650: rate_decode = 4'h6;
			`RATE_750: rate_decode = 4'h7;
			`RATE_1000: rate_decode = 4'h8;
			default: rate_decode = `RATE_IDX_BAD;
		endcase
	endfunction

	// Degrees scaled into the sync period measured by the previous cycle
	function automatic logic [CNT_W-1:0] deg_to_cnt(input logic [8:0] deg,
		input logic [CNT_W-1:0] period);
		logic [CNT_W+8:0] prod;
		prod = {9'h000, period} * {{CNT_W{1'b0}}, deg};
		deg_to_cnt = CNT_W'(prod / (CNT_W + 9)'(360));
	endfunction

	logic sync_fall;
	logic [CNT_W-1:0] since_fall;

	sync_edge_phase #(.CNT_W(CNT_W)) u_edge (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.sync_ref(sync_ref),
		.sync_fall(sync_fall),
		.since_fall(since_fall)
	);

	logic [7:0] phase_q, phase_d;
	logic [15:0] rate_q, rate_d;
	logic [3:0] ridx_q, ridx_d;
	fault_pulse_type flt_q, flt_d;
	relock_state_type st_q, st_d;
	logic [15:0] relock_q, relock_d;
	logic [CNT_W-1:0] period_q, period_d;
	logic st0_q, st0_d, st1_q, st1_d;
	logic shr_oe_q, shr_oe_d;
	logic first_up_q, first_up_d;
	logic is_off, wr_phase, wr_rate, relock_start;
	phase_pair_type pp;

	assign is_off = ~run_pins | ~cmd_on;
	assign wr_phase = cmd_wr.valid && cmd_wr.code == `CMD_PHASE_CFG;
	assign wr_rate = cmd_wr.valid && cmd_wr.code == `CMD_RATE_SEL;
	assign pp = phase_lookup(phase_q[`PHASE_LO:0]);

	always_comb begin
		phase_d = phase_q;
		rate_d = rate_q;
		ridx_d = ridx_q;
		flt_d = '0;
		flt_d.loop_unlock = relock_start;
		if ((wr_phase || wr_rate) && !is_off) begin
			flt_d.busy_fault = 1'b1;
		end else if (wr_phase) begin
			// Only the low byte is used; reserved bit 7 forced to zero, bit 3 kept
			phase_d = cmd_wr.data[7:0];
			phase_d[`BIT_RSVD_HI] = 1'b0;
		end else if (wr_rate) begin
			if (rate_decode(cmd_wr.data) == `RATE_IDX_BAD) begin
				flt_d.comm_fault = 1'b1;
			end else begin
				rate_d = cmd_wr.data;
				ridx_d = rate_decode(cmd_wr.data);
			end
		end
	end

	// Relock window after an accepted rate change; a further change restarts it
	always_comb begin
		st_d = st_q;
		relock_d = relock_q;
		relock_start = wr_rate && is_off && rate_decode(cmd_wr.data) != `RATE_IDX_BAD &&
			cmd_wr.data != rate_q;
		case (st_q)
			st_idle: begin
				st_d = st_idle;
			end
			st_relock: begin
				relock_d = relock_q - 16'h0001;
				if (relock_q == 16'h0001) begin
					st_d = st_idle;
				end
			end
			default: st_d = st_idle;
		endcase
		if (relock_start) begin
			st_d = st_relock;
			relock_d = `RELOCK_CYCLES;
		end
	end

	always_comb begin
		// The flag cycle shows the last count, which is one short of the period
		period_d = sync_fall ? since_fall + {{(CNT_W-1){1'b0}}, 1'b1} : period_q;
		// Starts fire at the offset after each falling edge, never on the rising edge
		st0_d = (since_fall == deg_to_cnt(pp.ch0_deg, period_q));
		st1_d = (since_fall == deg_to_cnt(pp.ch1_deg, period_q));
		first_up_d = first_up_q & ~vin_above_on;
		if (phase_q[`BIT_SHARE_EN]) begin
			// Once released, stays released until input drops below the off threshold
			shr_oe_d = shr_oe_q ? (~vin_above_on | vin_below_off) : vin_below_off;
		end else begin
			// Pulled low only until input first rises past the on threshold
			shr_oe_d = first_up_q & ~vin_above_on;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			phase_q <= `PHASE_CFG_RESET;
			rate_q <= `RATE_SEL_RESET;
			ridx_q <= rate_decode(`RATE_SEL_RESET);
			flt_q <= '0;
			st_q <= st_idle;
			relock_q <= '0;
			period_q <= '0;
			st0_q <= 1'b0;
			st1_q <= 1'b0;
			shr_oe_q <= 1'b1;
			first_up_q <= 1'b1;
		end else if (clk_en) begin
			phase_q <= phase_d;
			rate_q <= rate_d;
			ridx_q <= ridx_d;
			flt_q <= flt_d;
			st_q <= st_d;
			relock_q <= relock_d;
			period_q <= period_d;
			st0_q <= st0_d;
			st1_q <= st1_d;
			shr_oe_q <= shr_oe_d;
			first_up_q <= first_up_d;
		end
	end

	logic [17:0] pp_q;
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pp_q <= '0;
		end else if (clk_en) begin
			pp_q <= pp;
		end
	end

	assign share_clk_out = 1'b0;
	assign share_clk_oe = shr_oe_q;
	assign phase_cfg_rd = phase_q;
	assign rate_sel_rd = rate_q;
	assign out0_range_select = phase_q[`BIT_OUT0_RANGE];
	assign out1_range_select = phase_q[`BIT_OUT1_RANGE];
	assign phase_pair = pp_q;
	assign rate_index = ridx_q;
	assign ch0_phase_start = st0_q;
	assign ch1_phase_start = st1_q;
	assign faults = flt_q;
endmodule

// ---- design/pwm_cfg.svh ----
// Constants for the phase, range and switching-rate configuration block.
// Assumes inclusion by the package and by the top design module.
`ifndef PWM_CFG_SVH
`define PWM_CFG_SVH
`define CMD_PHASE_CFG 8'hF5
`define CMD_RATE_SEL 8'h33
`define PHASE_CFG_RESET 8'h10
`define RATE_SEL_RESET 16'hFABC
`define BIT_OUT0_RANGE 6
`define BIT_OUT1_RANGE 5
`define BIT_SHARE_EN 4
`define BIT_RSVD_HI 7
`define PHASE_LO 2
`define MAX_PHASE_CODE 3'h6
`define RATE_EXT 16'h0000
`define RATE_250 16'hF3E8
`define RATE_350 16'hFABC
`define RATE_425 16'hFB52
`define RATE_500 16'hFBE8
`define RATE_575 16'h023F
`define RATE_650 16'h028A
`define RATE_750 16'h02EE
`define RATE_1000 16'h03E8
`define RELOCK_CYCLES 16'h0400
`define RATE_IDX_EXT 4'h0
`define RATE_IDX_BAD 4'hF
`endif

// ---- design/pwm_cfg_pkg.sv ----
// Types for the phase, range and switching-rate configuration block.
// Assumes the constants header is on the include path.
package pwm_cfg_pkg;
`include "pwm_cfg.svh"
	typedef struct packed {
		logic valid;
		logic [7:0] code;
		logic [15:0] data;
	} cmd_write_type;
	typedef struct packed {
		logic [8:0] ch0_deg;
		logic [8:0] ch1_deg;
	} phase_pair_type;
	typedef struct packed {
		logic busy_fault;
		logic comm_fault;
		logic loop_unlock;
	} fault_pulse_type;
	typedef enum logic [1:0] {
		st_idle,
		st_relock
	} relock_state_type;
endpackage

// ---- design/sync_edge_phase.sv ----
// Falling-edge detector on the external sync reference and phase counter.
// Assumes sync_ref is already synchronous to ref_clk.
`timescale 1ns/1ps
module sync_edge_phase #(
	parameter int CNT_W = 16
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic sync_ref,
	output logic sync_fall,
	output logic [CNT_W-1:0] since_fall
);
	import pwm_cfg_pkg::*;
	logic prev_q, prev_d;
	logic fall_q, fall_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;

	always_comb begin
		prev_d = sync_ref;
		fall_d = prev_q & ~sync_ref;
		// Clears one cycle late so the flag cycle still shows the finished count
		cnt_d = fall_q ? '0 : cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			prev_q <= 1'b0;
			fall_q <= 1'b0;
			cnt_q <= '0;
		end else if (clk_en) begin
			prev_q <= prev_d;
			fall_q <= fall_d;
			cnt_q <= cnt_d;
		end
	end

	assign sync_fall = fall_q;
	assign since_fall = cnt_q;
endmodule

// ---- sim/pwm_cfg_asserts.sv ----
// Checker for the configuration block, watching its ports only.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/1ps
module pwm_cfg_asserts
	import pwm_cfg_pkg::*;
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire pwm_cfg_pkg::cmd_write_type cmd_wr,
	input wire logic run_pins,
	input wire logic cmd_on,
	input wire logic vin_below_off,
	input wire logic share_clk_out,
	input wire logic share_clk_oe,
	input wire logic [7:0] phase_cfg_rd,
	input wire logic [15:0] rate_sel_rd,
	input wire logic out0_range_select,
	input wire logic out1_range_select,
	input wire logic [3:0] rate_index,
	input wire pwm_cfg_pkg::fault_pulse_type faults
);
	logic wr, run, rate_wr, good;
	assign wr = clk_en && cmd_wr.valid;
	assign run = run_pins && cmd_on;
	assign rate_wr = wr && !run && cmd_wr.code == 8'h33;
	assign good = cmd_wr.data inside {16'h0000, 16'hF3E8, 16'hFABC, 16'hFB52, 16'hFBE8,
		16'h023F, 16'h028A, 16'h02EE, 16'h03E8};
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	busy_refuse_a: assert property (wr && run && cmd_wr.code inside {8'hF5, 8'h33} |=>
		faults.busy_fault && $stable(phase_cfg_rd) && $stable(rate_sel_rd))
		else $error("busy write kept");
	phase_take_a: assert property (wr && !run && cmd_wr.code == 8'hF5 |=>
		phase_cfg_rd == {1'b0, $past(cmd_wr.data[6:0])}) else $error("phase byte not stored");
	rate_take_a: assert property (rate_wr && good |=>
		rate_sel_rd == $past(cmd_wr.data)) else $error("rate code not stored");
	rate_bad_a: assert property (rate_wr && !good |=>
		faults.comm_fault && $stable(rate_sel_rd)) else $error("bad rate code kept");
	relock_flag_a: assert property (rate_wr && good && cmd_wr.data != rate_sel_rd |=>
		faults.loop_unlock) else $error("no unlock pulse");
	top_index_a: assert property (rate_wr && cmd_wr.data == 16'h03E8 |=>
		rate_index == 4'h8) else $error("wrong rate index");
	range_bits_a: assert property (out0_range_select == phase_cfg_rd[6]
		&& out1_range_select == phase_cfg_rd[5]) else $error("range select mismatch");
	share_hold_a: assert property (clk_en && phase_cfg_rd[4] && vin_below_off |=>
		share_clk_oe) else $error("shared clock released");
	share_low_a: assert property (share_clk_out == 1'b0)
		else $error("open drain driven high");
	cover property (faults.busy_fault);
	cover property (faults.comm_fault);
	cover property (faults.loop_unlock);
endmodule
bind pwm_phase_frequency_config pwm_cfg_asserts pwm_cfg_asserts_inst (.ref_clk, .sys_rst,
	.clk_en, .cmd_wr, .run_pins, .cmd_on, .vin_below_off, .share_clk_out, .share_clk_oe,
	.phase_cfg_rd, .rate_sel_rd, .out0_range_select, .out1_range_select, .rate_index, .faults);

// ---- sim/pmbus_host_model.sv ----
// Host side model that delivers decoded command writes.
// Assumes the block takes a write on the edge after valid rises.
`timescale 1ns/1ps
module pmbus_host_model (
	input wire logic ref_clk,
	output pwm_cfg_pkg::cmd_write_type cmd_wr
);
	import pwm_cfg_pkg::*;
	initial cmd_wr = '0;
	task automatic send(input logic [7:0] code, input logic [15:0] data);
		@(posedge ref_clk);
		cmd_wr <= {1'b1, code, data};
		@(posedge ref_clk);
		// Stale fields are inverted so nothing leans on them
		cmd_wr <= {1'b0, ~code, ~data};
	endtask
endmodule

// ---- sim/test_pwm_phase_frequency_config.sv ----
// Self-checking bench for the configuration block.
// Assumes the host model and the bound checker.
`timescale 1ns/1ps
module test_pwm_phase_frequency_config;
	import pwm_cfg_pkg::*;
	typedef struct {logic [7:0] c; logic [15:0] d, rd; logic [17:0] aux;} row_type;
	logic ref_clk = 0, sys_rst = 1, clk_en = 1, run_pins = 0, cmd_on = 1, sync_ref = 0;
	logic vin_above_on = 0, vin_below_off = 1, share_clk_in = 0, share_clk_out, share_clk_oe;
	logic out0_range_select, out1_range_select, ch0_phase_start, ch1_phase_start;
	logic [7:0] phase_cfg_rd;
	logic [15:0] rate_sel_rd;
	logic [3:0] rate_index;
	cmd_write_type cmd_wr;
	phase_pair_type phase_pair;
	fault_pulse_type faults;
	int n_fail = 0, cmp_count = 0, cyc = 0;
	int t0 = 0, t1 = 0;
	// Edge flag, count clear and start register each cost one cycle
	localparam int START_LAT = 3;
	row_type rows[16] = '{'{8'hF5, 16'h40, 16'h40, {9'd0, 9'd180}},
		'{8'hF5, 16'h21, 16'h21, {9'd90, 9'd270}}, '{8'hF5, 16'h8A, 16'h0A, {9'd0, 9'd240}},
		'{8'hF5, 16'h73, 16'h73, {9'd0, 9'd120}}, '{8'hF5, 16'h04, 16'h04, {9'd120, 9'd240}},
		'{8'hF5, 16'h15, 16'h15, {9'd60, 9'd240}}, '{8'hF5, 16'h66, 16'h66, {9'd120, 9'd300}},
		'{8'h33, 16'h0000, 16'h0000, 0}, '{8'h33, 16'hF3E8, 16'hF3E8, 1},
		'{8'h33, 16'hFABC, 16'hFABC, 2}, '{8'h33, 16'hFB52, 16'hFB52, 3},
		'{8'h33, 16'hFBE8, 16'hFBE8, 4}, '{8'h33, 16'h023F, 16'h023F, 5},
		'{8'h33, 16'h028A, 16'h028A, 6}, '{8'h33, 16'h02EE, 16'h02EE, 7},
		'{8'h33, 16'h03E8, 16'h03E8, 8}};
	pwm_phase_frequency_config pwm_phase_frequency_config_inst (.ref_clk, .sys_rst, .clk_en,
		.cmd_wr, .run_pins, .cmd_on, .sync_ref, .vin_above_on, .vin_below_off, .share_clk_in,
		.share_clk_out, .share_clk_oe, .phase_cfg_rd, .rate_sel_rd, .out0_range_select,
		.out1_range_select, .phase_pair, .rate_index, .ch0_phase_start, .ch1_phase_start, .faults);
	pmbus_host_model pmbus_host_model_inst (.ref_clk, .cmd_wr);
	initial forever #5 ref_clk = ~ref_clk;
	task automatic chk(input logic [23:0] got, exp, input string m);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask
	task automatic hit(input logic [7:0] c, input logic [15:0] d, input logic [2:0] f);
		pmbus_host_model_inst.send(c, d);
		#1;
		chk(faults, f, "fault pulse");
	endtask
	task automatic final_report;
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Ceiling well above the few hundred cycles the run needs
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		sync_ref <= cyc[5];
		if (cyc == 5000) begin
			n_fail++;
			final_report;
		end
	end
	initial begin
		repeat (16) @(posedge ref_clk);
		sys_rst <= 1'b0;
		foreach (rows[i]) begin
			pmbus_host_model_inst.send(rows[i].c, rows[i].d);
			repeat (2) @(posedge ref_clk);
			#1;
			if (rows[i].c == 8'hF5) begin
				chk(phase_cfg_rd, rows[i].rd, "phase byte");
				chk(phase_pair, rows[i].aux, "phase pair");
				chk(out0_range_select, rows[i].rd[6], "range 0");
				chk(out1_range_select, rows[i].rd[5], "range 1");
			end else begin
				chk(rate_sel_rd, rows[i].rd, "rate code");
				chk(rate_index, rows[i].aux, "rate index");
			end
		end
		$display("table test done");
		@(posedge ref_clk) sys_rst <= 1'b1;
		repeat (16) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk) #1;
		chk({phase_cfg_rd, rate_sel_rd}, 24'h10FABC, "reset regs");
		chk({rate_index, share_clk_oe}, 5'h05, "reset index");
		$display("reset test done");
		@(posedge ref_clk) run_pins <= 1'b1;
		hit(8'hF5, 16'h03, 3'b100);
		hit(8'h33, 16'h03E8, 3'b100);
		chk({phase_cfg_rd, rate_sel_rd}, 24'h10FABC, "busy kept");
		@(posedge ref_clk) cmd_on <= 1'b0;
		hit(8'h33, 16'h1234, 3'b010);
		hit(8'h33, 16'h03E8, 3'b001);
		hit(8'h33, 16'h03E8, 3'b000);
		$display("fault test done");
		pmbus_host_model_inst.send(8'hF5, 16'h00);
		vin_above_on <= 1'b1;
		vin_below_off <= 1'b0;
		repeat (3) @(posedge ref_clk);
		vin_above_on <= 1'b0;
		vin_below_off <= 1'b1;
		repeat (3) @(posedge ref_clk);
		#1;
		chk(share_clk_oe, 1'b0, "share released");
		pmbus_host_model_inst.send(8'hF5, 16'h10);
		repeat (3) @(posedge ref_clk);
		#1;
		chk(share_clk_oe, 1'b1, "share pulled");
		$display("share test done");
		pmbus_host_model_inst.send(8'hF5, 16'h17);
		repeat (2) @(posedge ref_clk);
		#1;
		chk(phase_pair, {9'd0, 9'd180}, "unlisted pair");
		// Two falls first, so the measured period is a whole one
		repeat (3) @(negedge sync_ref);
		#1;
		while (!ch0_phase_start && t0 < 64) begin
			@(posedge ref_clk);
			#1;
			t0++;
		end
		t1 = t0;
		while (!ch1_phase_start && t1 < 128) begin
			@(posedge ref_clk);
			#1;
			t1++;
		end
		chk(24'(t0), 24'(START_LAT), "channel 0 start");
		chk(24'(t1 - t0), 24'd32, "channel 1 start");
		$display("phase test done");
		clk_en <= 1'b0;
		hit(8'hF5, 16'h05, 3'b000);
		chk(phase_cfg_rd, 8'h17, "frozen byte");
		clk_en <= 1'b1;
		$display("enable test done");
		final_report;
	end
endmodule
